// ### design/bmsq_gate_drv.sv
// bmsq_gate_drv: alternating half-bridge gate timer with fixed deadtime.
// assumes the sequencer holds half_period stable enough to be sampled per phase.
`timescale 1ns/1ps
`default_nettype none
module bmsq_gate_drv (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  bmsq_gate_if.drv gif
);

  // ==========================================================================
  // phase sequencer
  bmsq_pkg::bmsq_phase_t phase_r, phase_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic lo_r, lo_nxt;
  logic ho_r, ho_nxt;
  logic end_r, end_nxt;

  // equal on-times and equal dead gaps give the 50% duty
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r + 12'h001;
    end_nxt = 1'b0;
    if (!gif.osc_run) begin
      phase_nxt = bmsq_pkg::BMSQ_DEAD_LO;
      cnt_nxt = 12'h000;
    end else begin
      unique case (phase_r)
        bmsq_pkg::BMSQ_DEAD_LO: begin
          if (cnt_r >= bmsq_pkg::DEAD_CYC - 12'h001) begin
            phase_nxt = bmsq_pkg::BMSQ_LO_ON;
            cnt_nxt = 12'h000;
          end
        end
        bmsq_pkg::BMSQ_LO_ON: begin
          if (cnt_r >= gif.half_period - 12'h001) begin
            phase_nxt = bmsq_pkg::BMSQ_DEAD_HO;
            cnt_nxt = 12'h000;
            end_nxt = 1'b1;
          end
        end
        bmsq_pkg::BMSQ_DEAD_HO: begin
          if (cnt_r >= bmsq_pkg::DEAD_CYC - 12'h001) begin
            phase_nxt = bmsq_pkg::BMSQ_HO_ON;
            cnt_nxt = 12'h000;
          end
        end
        bmsq_pkg::BMSQ_HO_ON: begin
          if (cnt_r >= gif.half_period - 12'h001) begin
            phase_nxt = bmsq_pkg::BMSQ_DEAD_LO;
            cnt_nxt = 12'h000;
          end
        end
      endcase
    end
    // gates follow the next phase so they never overlap
    lo_nxt = gif.osc_run && (phase_nxt == bmsq_pkg::BMSQ_LO_ON);
    // high side waits for its floating supply
    ho_nxt = gif.osc_run && gif.hs_enable && (phase_nxt == bmsq_pkg::BMSQ_HO_ON);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r <= bmsq_pkg::BMSQ_DEAD_LO;
      cnt_r <= 12'h000;
      lo_r <= 1'b0;
      ho_r <= 1'b0;
      end_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      lo_r <= lo_nxt;
      ho_r <= ho_nxt;
      end_r <= end_nxt;
    end
  end

  assign gif.lo_on = lo_r;
  assign gif.ho_on = ho_r;
  assign gif.lo_cycle_end = end_r;

endmodule
`default_nettype wire

// ### design/bmsq_gate_if.sv
// bmsq_gate_if: link between the sequencer and its half-bridge gate timer.
// assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface bmsq_gate_if;
  logic osc_run;
  logic hs_enable;
  logic [11:0] half_period;
  logic lo_on;
  logic ho_on;
  logic lo_cycle_end;

  modport seq (output osc_run, output hs_enable, output half_period,
               input lo_on, input ho_on, input lo_cycle_end);
  modport drv (input osc_run, input hs_enable, input half_period,
               output lo_on, output ho_on, output lo_cycle_end);
endinterface
`default_nettype wire

// ### design/bmsq_pkg.sv
// bmsq_pkg: constants, field layouts and state encodings of the ballast
// mode sequencer.
// assumes a single 100 MHz system clock; no other design file holds a tuning constant.
package bmsq_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEADTIME_NS = 1600;
  // least time, so round up to whole cycles
  localparam int DEAD_CYC_INT = (DEADTIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] DEAD_CYC = DEAD_CYC_INT[11:0];
  localparam int RAMP_TICK_NS = 1000;
  localparam int RAMP_DIV_INT = RAMP_TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0] RAMP_DIV = RAMP_DIV_INT[7:0];

  // ==========================================================================
  // oscillator shaping (half period in clock cycles)
  localparam logic [11:0] HALF_BASE_RESET = 12'h1f4;
  localparam logic [11:0] SOFT_OFFSET = 12'h12c;
  localparam logic [11:0] REG_STEP = 12'h004;
  localparam logic [11:0] MIN_HALF = 12'h032;

  // ==========================================================================
  // fault counter
  localparam logic [6:0] FAULT_EVENT_LIMIT = 7'h41;

  // ==========================================================================
  // comparator flag positions in the synchroniser vector
  localparam int NUM_FLAGS = 10;
  localparam int F_SUPPLY_START = 0;
  localparam int F_SUPPLY_STOP = 1;
  localparam int F_FLOAT_START = 2;
  localparam int F_SD_RELEASE = 3;
  localparam int F_SD_TRIP = 4;
  localparam int F_OVERCURRENT = 5;
  localparam int F_TIMER_UPPER = 6;
  localparam int F_TIMER_LOWER = 7;
  localparam int F_WEAROUT = 8;
  localparam int F_BUS_LOW = 9;

  // ==========================================================================
  // register map, byte addresses on the wishbone bus
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_HALF_LSB = 8;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_COUNT_LSB = 8;
  localparam int STAT_HS_BIT = 16;
  localparam int STAT_BUSUV_BIT = 17;

  // ==========================================================================
  // encodings, gray along the usual path
  typedef enum logic [2:0] {
    BMSQ_LOCKOUT = 3'h0,
    BMSQ_PREHEAT = 3'h1,
    BMSQ_IGN_DISCH = 3'h3,
    BMSQ_IGNITION = 3'h2,
    BMSQ_RUN = 3'h6,
    BMSQ_FAULT = 3'h7
  } bmsq_mode_t;

  typedef enum logic [1:0] {
    BMSQ_DEAD_LO = 2'h0,
    BMSQ_LO_ON = 2'h1,
    BMSQ_DEAD_HO = 2'h3,
    BMSQ_HO_ON = 2'h2
  } bmsq_phase_t;

endpackage

// ### design/bmsq_sequencer.sv
// bmsq_sequencer: lockout, preheat, ignition, run and fault sequencing of a
// lamp ballast, with over-current counter and ignition regulation.
// assumes comparator flags arrive asynchronously and software sits on wishbone.
//
// Function
// - in lockout both gates low, oscillator stopped, timer node grounded.
// - leave lockout only with supply above start and shutdown below release.
// - high-side gate stays off until the floating supply flag is set.
// - gates alternate at 50% duty, never together, 1.6 us dead gap.
// - bootstrap switch is on only while the low-side gate is on.
// - preheat releases timer, starts at soft-start frequency, ramps down.
// - preheat keeps the frequency node grounded through the resistor switch.
// - preheat lasts until timer exceeds upper level, then ignition.
// - preheat enables over-current detection and the 65-event counter.
// - power-factor stage in high gain during preheat and ignition.
// - first upper crossing discharges timer to lower level; second ends ignition.
// - entering ignition opens the frequency node switch to ramp down.
// - ignition over-current raises the frequency at once, every cycle.
// - counter off in ignition, on again at second crossing with run.
// - run disables regulation; 65 consecutive faults latch all gates low.
// - ignition ignores the shutdown and wear-out fault inputs.
// - in run each over-current cycle increments the counter.
// - wear-out window and bus undervoltage checks only in run.
// - each clean cycle decrements the counter toward zero.
// - over-current counts only while the low-side gate is on.
// - fault latches gates low and grounds timer and frequency nodes.
// - fault exits only to lockout on supply stop or shutdown trip; the code also exits when the enable bit is cleared.
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module bmsq_sequencer (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // comparator flags, asynchronous
  input wire logic supply_start_threshold_in,
  input wire logic supply_stop_threshold_in,
  input wire logic floating_supply_start_threshold_in,
  input wire logic shutdown_release_threshold_in,
  input wire logic shutdown_trip_threshold_in,
  input wire logic overcurrent_threshold_in,
  input wire logic timer_upper_threshold_in,
  input wire logic timer_lower_threshold_in,
  input wire logic lamp_wearout_window_in,
  input wire logic bus_undervoltage_in,
  // power stage and analog switch controls
  output logic high_side_gate_out,
  output logic low_side_gate_out,
  output logic bootstrap_switch_out,
  output logic preheat_timer_discharge_out,
  output logic preheat_resistor_switch_out,
  output logic frequency_control_discharge_out,
  output logic frequency_raise_out,
  output logic [11:0] half_period_out,
  output logic pfc_high_gain_out,
  output logic pfc_gate_enable_out,
  output logic supply_discharge_out,
  output logic wearout_check_enable_out,
  output logic bus_uv_enable_out,
  // wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);

  // ==========================================================================
  // flag synchronisers
  logic [bmsq_pkg::NUM_FLAGS-1:0] flag_raw;
  logic [bmsq_pkg::NUM_FLAGS-1:0] meta_r;
  logic [bmsq_pkg::NUM_FLAGS-1:0] flag_r;

  assign flag_raw = {bus_undervoltage_in, lamp_wearout_window_in,
                     timer_lower_threshold_in, timer_upper_threshold_in,
                     overcurrent_threshold_in, shutdown_trip_threshold_in,
                     shutdown_release_threshold_in, floating_supply_start_threshold_in,
                     supply_stop_threshold_in, supply_start_threshold_in};

  // first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < bmsq_pkg::NUM_FLAGS; gi = gi + 1) begin : g_sync
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_r[gi] <= 1'b0;
          flag_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= flag_raw[gi];
          flag_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  logic sup_start, sup_stop, float_ok, sd_hi, sd_trip, oc, t_up, t_low, wear, bus_low;
  assign sup_start = flag_r[bmsq_pkg::F_SUPPLY_START];
  assign sup_stop = flag_r[bmsq_pkg::F_SUPPLY_STOP];
  assign float_ok = flag_r[bmsq_pkg::F_FLOAT_START];
  assign sd_hi = flag_r[bmsq_pkg::F_SD_RELEASE];
  assign sd_trip = flag_r[bmsq_pkg::F_SD_TRIP];
  assign oc = flag_r[bmsq_pkg::F_OVERCURRENT];
  assign t_up = flag_r[bmsq_pkg::F_TIMER_UPPER];
  assign t_low = flag_r[bmsq_pkg::F_TIMER_LOWER];
  assign wear = flag_r[bmsq_pkg::F_WEAROUT];
  assign bus_low = flag_r[bmsq_pkg::F_BUS_LOW];

  // ==========================================================================
  // wishbone registers
  logic enable_r, enable_nxt;
  logic [11:0] half_base_r, half_base_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [31:0] status_w;
  logic wb_req;
  bmsq_pkg::bmsq_mode_t mode_r, mode_nxt;
  logic [6:0] count_r, count_nxt;
  logic busuv_r, busuv_nxt;

  assign wb_req = wb_cyc_in && wb_stb_in && !ack_r;

  // status shows the sequencer's own state
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[bmsq_pkg::STAT_MODE_LSB +: 3] = mode_r;
    status_w[bmsq_pkg::STAT_COUNT_LSB +: 7] = count_r;
    status_w[bmsq_pkg::STAT_HS_BIT] = float_ok;
    status_w[bmsq_pkg::STAT_BUSUV_BIT] = busuv_r;
  end

  // single-wait answer; unmapped reads give zero, unmapped writes vanish
  always_comb begin
    enable_nxt = enable_r;
    half_base_nxt = half_base_r;
    ack_nxt = wb_req;
    rdat_nxt = rdat_r;
    if (wb_req && wb_we_in && wb_adr_in == bmsq_pkg::ADR_CTRL) begin
      if (wb_sel_in[0]) begin
        enable_nxt = wb_dat_in[bmsq_pkg::CTRL_ENABLE_BIT];
      end
      if (wb_sel_in[1]) begin
        half_base_nxt[7:0] = wb_dat_in[bmsq_pkg::CTRL_HALF_LSB +: 8];
      end
      if (wb_sel_in[2]) begin
        half_base_nxt[11:8] = wb_dat_in[bmsq_pkg::CTRL_HALF_LSB + 8 +: 4];
      end
    end
    if (wb_req && !wb_we_in) begin
      if (wb_adr_in == bmsq_pkg::ADR_CTRL) begin
        rdat_nxt = 32'h0000_0000;
        rdat_nxt[bmsq_pkg::CTRL_ENABLE_BIT] = enable_r;
        rdat_nxt[bmsq_pkg::CTRL_HALF_LSB +: 12] = half_base_r;
      end else if (wb_adr_in == bmsq_pkg::ADR_STATUS) begin
        rdat_nxt = status_w;
      end else begin
        rdat_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_r <= 1'b1;
      half_base_r <= bmsq_pkg::HALF_BASE_RESET;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      enable_r <= enable_nxt;
      half_base_r <= half_base_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdat_r;

  // ==========================================================================
  // gate timer
  bmsq_gate_if gif ();

  bmsq_gate_drv u_gate (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .gif(gif)
  );

  // ==========================================================================
  // ramp divider: one-cycle tick for the soft-start and frequency decay
  logic [7:0] div_r, div_nxt;
  logic tick;

  assign tick = (div_r == bmsq_pkg::RAMP_DIV - 8'h01);

  always_comb begin
    div_nxt = tick ? 8'h00 : div_r + 8'h01;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ==========================================================================
  // mode sequencer, fault counter and ignition regulation
  logic oc_seen_r, oc_seen_nxt;
  logic [11:0] offset_r, offset_nxt;
  logic raise_r, raise_nxt;
  logic oc_hit, counting, regulating, any_seen, limit_hit;

  // only over-current while the low side conducts matters
  assign oc_hit = oc && gif.lo_on;
  assign any_seen = oc_seen_r || oc_hit;
  // counter live in preheat and run only
  assign counting = (mode_r == bmsq_pkg::BMSQ_PREHEAT) || (mode_r == bmsq_pkg::BMSQ_RUN);
  // regulation lives only in ignition
  assign regulating = (mode_r == bmsq_pkg::BMSQ_IGN_DISCH) ||
                      (mode_r == bmsq_pkg::BMSQ_IGNITION);
  assign limit_hit = counting && gif.lo_cycle_end && any_seen &&
                     (count_r == bmsq_pkg::FAULT_EVENT_LIMIT - 7'h01);

  always_comb begin
    mode_nxt = mode_r;
    busuv_nxt = busuv_r;
    unique case (mode_r)
      bmsq_pkg::BMSQ_LOCKOUT: begin
        if (enable_r && sup_start && !sup_stop && !sd_hi) begin
          mode_nxt = bmsq_pkg::BMSQ_PREHEAT;
          busuv_nxt = 1'b0;
        end
      end
      bmsq_pkg::BMSQ_PREHEAT: begin
        if (limit_hit) begin
          mode_nxt = bmsq_pkg::BMSQ_FAULT;
        end else if (t_up) begin
          mode_nxt = bmsq_pkg::BMSQ_IGN_DISCH;
        end
      end
      bmsq_pkg::BMSQ_IGN_DISCH: begin
        if (t_low) begin
          mode_nxt = bmsq_pkg::BMSQ_IGNITION;
        end
      end
      bmsq_pkg::BMSQ_IGNITION: begin
        // shutdown and wear-out are not looked at here
        if (t_up) begin
          mode_nxt = bmsq_pkg::BMSQ_RUN;
        end
      end
      bmsq_pkg::BMSQ_RUN: begin
        if (limit_hit || wear || bus_low) begin
          mode_nxt = bmsq_pkg::BMSQ_FAULT;
          busuv_nxt = bus_low;
        end
      end
      bmsq_pkg::BMSQ_FAULT: begin
        mode_nxt = bmsq_pkg::BMSQ_FAULT; // latched
      end
      default: begin
        mode_nxt = bmsq_pkg::BMSQ_LOCKOUT;
      end
    endcase
    // leaving for lockout, from fault only this way
    if (sup_stop || !enable_r) begin
      mode_nxt = bmsq_pkg::BMSQ_LOCKOUT;
    end else if (sd_trip && mode_r != bmsq_pkg::BMSQ_IGN_DISCH &&
                 mode_r != bmsq_pkg::BMSQ_IGNITION) begin
      mode_nxt = bmsq_pkg::BMSQ_LOCKOUT;
    end
  end

  // up/down fault counter, one step per low-side cycle
  always_comb begin
    count_nxt = count_r;
    oc_seen_nxt = gif.lo_cycle_end ? 1'b0 : any_seen;
    if (!counting) begin
      count_nxt = 7'h00; // held clear in ignition and elsewhere
    end else if (gif.lo_cycle_end) begin
      if (any_seen) begin
        if (count_r != bmsq_pkg::FAULT_EVENT_LIMIT) begin
          count_nxt = count_r + 7'h01;
        end
      end else if (count_r != 7'h00) begin
        count_nxt = count_r - 7'h01;
      end
    end
  end

  // soft-start offset decays with the tick; regulation pushes it back up
  always_comb begin
    offset_nxt = offset_r;
    raise_nxt = 1'b0;
    if (mode_r == bmsq_pkg::BMSQ_LOCKOUT || mode_r == bmsq_pkg::BMSQ_FAULT) begin
      offset_nxt = bmsq_pkg::SOFT_OFFSET; // next start is soft
    end else if (regulating && oc_hit && !oc_seen_r) begin
      raise_nxt = 1'b1; // once per cycle, at the first sign
      if (offset_r <= 12'hfff - bmsq_pkg::REG_STEP) begin
        offset_nxt = offset_r + bmsq_pkg::REG_STEP;
      end
    end else if (tick && offset_r != 12'h000) begin
      offset_nxt = offset_r - 12'h001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r <= bmsq_pkg::BMSQ_LOCKOUT;
      busuv_r <= 1'b0;
      count_r <= 7'h00;
      oc_seen_r <= 1'b0;
      offset_r <= bmsq_pkg::SOFT_OFFSET;
      raise_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      busuv_r <= busuv_nxt;
      count_r <= count_nxt;
      oc_seen_r <= oc_seen_nxt;
      offset_r <= offset_nxt;
      raise_r <= raise_nxt;
    end
  end

  // ==========================================================================
  // mode-decoded outputs
  logic active;
  logic [11:0] half_w;

  // higher frequency means shorter half period, floored for safety
  assign half_w = ({1'b0, half_base_r} > 13'(offset_r) + 13'(bmsq_pkg::MIN_HALF)) ?
                  half_base_r - offset_r : bmsq_pkg::MIN_HALF;
  // oscillator stopped in lockout and fault
  assign active = (mode_r != bmsq_pkg::BMSQ_LOCKOUT) && (mode_r != bmsq_pkg::BMSQ_FAULT);

  assign gif.osc_run = active;
  assign gif.hs_enable = float_ok;
  assign gif.half_period = half_w;

  assign high_side_gate_out = gif.ho_on;
  assign low_side_gate_out = gif.lo_on;
  assign bootstrap_switch_out = gif.lo_on;
  assign half_period_out = half_w;
  assign frequency_raise_out = raise_r;
  // timer grounded in lockout, quick discharge, and fault
  assign preheat_timer_discharge_out = (mode_r == bmsq_pkg::BMSQ_LOCKOUT) ||
                                       (mode_r == bmsq_pkg::BMSQ_IGN_DISCH) ||
                                       (mode_r == bmsq_pkg::BMSQ_FAULT);
  // closed only in preheat
  assign preheat_resistor_switch_out = (mode_r == bmsq_pkg::BMSQ_PREHEAT);
  assign frequency_control_discharge_out = (mode_r == bmsq_pkg::BMSQ_FAULT);
  assign pfc_high_gain_out = (mode_r == bmsq_pkg::BMSQ_PREHEAT) || regulating;
  assign pfc_gate_enable_out = active;
  assign supply_discharge_out = (mode_r == bmsq_pkg::BMSQ_FAULT) && busuv_r;
  assign wearout_check_enable_out = (mode_r == bmsq_pkg::BMSQ_RUN);
  assign bus_uv_enable_out = (mode_r == bmsq_pkg::BMSQ_RUN);

endmodule
`default_nettype wire

// ### verif/bmsq_analog_model.sv
// bmsq_analog_model: timer capacitor and floating supply around the sequencer.
// assumes the bench clock; levels are coarse counts, not volts.
`timescale 1ns/1ps
`default_nettype none
module bmsq_analog_model (
  input wire logic sys_clk_in,
  input wire logic timer_discharge_in,
  input wire logic boot_on_in,
  input wire logic powered_in,
  output wire logic timer_upper_out,
  output wire logic timer_lower_out,
  output wire logic float_ok_out
);
  // ==========================================
  // timer charges slowly and discharges four times faster
  logic [11:0] cap = 12'h000;
  logic [1:0] boots = 2'h0;
  logic boot_d = 1'b0;
  always @(posedge sys_clk_in) begin
    if (timer_discharge_in) cap <= (cap < 12'h004) ? 12'h000 : cap - 12'h004;
    else if (cap != 12'hfff) cap <= cap + 12'h001;
    boot_d <= boot_on_in;
    // floating supply needs three charge pulses, lost when unpowered
    if (!powered_in) boots <= 2'h0;
    else if (boot_on_in && !boot_d && boots != 2'h3) boots <= boots + 2'h1;
  end
  assign float_ok_out = (boots == 2'h3);
  assign timer_upper_out = (cap >= 12'h800);
  assign timer_lower_out = (cap <= 12'h200);
endmodule
`default_nettype wire

// ### verif/bmsq_monitor.sv
// bmsq_monitor: port-level checks of the ballast mode sequencer.
// assumes a bind onto bmsq_sequencer, same clock and reset.
`timescale 1ns/1ps
`default_nettype none
module bmsq_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic supply_start_threshold_in,
  input wire logic shutdown_release_threshold_in,
  input wire logic floating_supply_start_threshold_in,
  input wire logic high_side_gate_out,
  input wire logic low_side_gate_out,
  input wire logic preheat_timer_discharge_out,
  input wire logic preheat_resistor_switch_out,
  input wire logic frequency_control_discharge_out,
  input wire logic frequency_raise_out,
  input wire logic pfc_high_gain_out,
  input wire logic pfc_gate_enable_out,
  input wire logic wearout_check_enable_out,
  input wire logic bus_uv_enable_out
);
  // ==========================================
  // helpers: lockout decode and both-low run length
  logic lock, quiet;
  logic [11:0] gap_r, gap_nxt;
  assign lock = !pfc_gate_enable_out && !frequency_control_discharge_out;
  assign quiet = !high_side_gate_out && !low_side_gate_out;
  // saturates so a long idle never wraps into a false short gap
  always_comb begin
    gap_nxt = gap_r + 12'h001;
    if (!quiet) gap_nxt = 12'h000;
    else if (&gap_r) gap_nxt = gap_r;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) gap_r <= 12'hfff;
    else gap_r <= gap_nxt;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // one cycle of gate register lag is allowed after entering fault, two after entering lockout
  sequence s_lock_held; lock [*3]; endsequence
  sequence s_fault_held; frequency_control_discharge_out [*2]; endsequence
  a_lock_quiet:
    assert property (s_lock_held |-> quiet && preheat_timer_discharge_out)
      else $error("gate or timer active in lockout");
  a_start_cond:
    assert property ($rose(pfc_gate_enable_out) |-> $past(supply_start_threshold_in, 3)
      && !$past(shutdown_release_threshold_in, 3)) else $error("start without its flags");
  a_hs_wait:
    assert property (high_side_gate_out |-> $past(floating_supply_start_threshold_in, 3))
      else $error("high gate before floating supply");
  a_dead_gap:
    assert property ($rose(high_side_gate_out) || $rose(low_side_gate_out)
      |-> gap_r >= bmsq_pkg::DEAD_CYC) else $error("dead gap too short");
  a_preheat_cfg:
    assert property (preheat_resistor_switch_out |-> !preheat_timer_discharge_out
      && pfc_high_gain_out) else $error("preheat switches wrong");
  a_raise_ign:
    assert property (frequency_raise_out |-> pfc_high_gain_out
      && !preheat_resistor_switch_out) else $error("raise outside ignition");
  a_run_checks:
    assert property (wearout_check_enable_out |-> bus_uv_enable_out && !pfc_high_gain_out)
      else $error("wear-out check outside run");
  a_fault_latch:
    assert property (s_fault_held |-> quiet && !pfc_gate_enable_out
      && preheat_timer_discharge_out) else $error("fault not latched");
endmodule
bind bmsq_sequencer bmsq_monitor i_mon (.*);
`default_nettype wire

// ### verif/bmsq_sequencer_tb.sv
// bmsq_sequencer_tb: self-checking bench for the ballast mode sequencer.
// assumes the analog model plays timer and floating supply.
`timescale 1ns/1ps
`default_nettype none
module bmsq_sequencer_tb;
  // ==========================================
  // harness
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
  typedef struct packed {logic we; logic [7:0] adr; logic [31:0] dat; logic [31:0] exp;} bmsq_row_t;
  localparam bmsq_row_t ROWS [7] = '{'{1'b0, bmsq_pkg::ADR_CTRL, 32'h0, 32'h0001f401},
    '{1'b0, bmsq_pkg::ADR_STATUS, 32'h0, 32'h0}, '{1'b1, bmsq_pkg::ADR_CTRL, 32'h4001, 32'h0},
    '{1'b0, bmsq_pkg::ADR_CTRL, 32'h0, 32'h4001}, '{1'b1, 8'h0c, 32'hffffffff, 32'h0},
    '{1'b0, 8'h08, 32'h0, 32'h0}, '{1'b0, bmsq_pkg::ADR_CTRL, 32'h0, 32'h4001}};
  logic sys_clk_in, rst_n_in, cyc, stb, we, sup, stp, rel, trip, oc, wear, busuv, tu, tl, fl;
  logic hs, ls, boot, ptd, prs, fcd, raise, hg, pge, wce, bue, ack, sd;
  logic [7:0] adr;
  logic [11:0] half;
  logic [31:0] dat, wbd, rd;
  int err_total = 0, num_checks = 0, cyc_n = 0, lo_n = 0, raise_n = 0, k, m0;
  bmsq_sequencer i_dut (.sys_clk_in, .rst_n_in, .supply_start_threshold_in(sup),
    .supply_stop_threshold_in(stp), .floating_supply_start_threshold_in(fl),
    .shutdown_release_threshold_in(rel), .shutdown_trip_threshold_in(trip),
    .overcurrent_threshold_in(oc), .timer_upper_threshold_in(tu), .timer_lower_threshold_in(tl),
    .lamp_wearout_window_in(wear), .bus_undervoltage_in(busuv), .high_side_gate_out(hs),
    .low_side_gate_out(ls), .bootstrap_switch_out(boot), .preheat_timer_discharge_out(ptd),
    .preheat_resistor_switch_out(prs), .frequency_control_discharge_out(fcd),
    .frequency_raise_out(raise), .half_period_out(half), .pfc_high_gain_out(hg),
    .pfc_gate_enable_out(pge), .supply_discharge_out(sd), .wearout_check_enable_out(wce),
    .bus_uv_enable_out(bue), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(wbd), .wb_ack_out(ack));
  bmsq_analog_model i_ana (.sys_clk_in, .timer_discharge_in(ptd), .boot_on_in(boot),
    .powered_in(pge), .timer_upper_out(tu), .timer_lower_out(tl), .float_ok_out(fl));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // hang guard, twice the run
  always @(posedge sys_clk_in) begin
    cyc_n++;
    if (raise === 1'b1) raise_n++;
    if (cyc_n == 90000) begin
      err_total++;
      end_sim;
    end
  end
  always @(posedge ls) lo_n++;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge sys_clk_in);
    while (ack !== 1'b1);
    rd = wbd;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic stat;
    wb(1'b0, bmsq_pkg::ADR_STATUS, 32'h0);
  endtask
  task automatic wait_mode(input logic [2:0] m);
    do stat;
    while (rd[2:0] !== m);
  endtask
  // ==========================================
  // sequence
  initial begin
    {rst_n_in, cyc, stb, we, adr, dat, sup, stp, rel, trip, oc, wear, busuv} = '0;
    repeat (6) @(posedge sys_clk_in);
    `CHK({ptd, hs, ls, pge, half}, 16'h80c8)
    rst_n_in <= 1'b1;
    foreach (ROWS[i]) begin
      wb(ROWS[i].we, ROWS[i].adr, ROWS[i].dat);
      if (!ROWS[i].we) `CHK(rd, ROWS[i].exp)
    end
    {sup, rel} <= 2'b11;
    repeat (40) @(posedge sys_clk_in);
    `CHK(pge, 1'b0)
    rel <= 1'b0;
    wait_mode(bmsq_pkg::BMSQ_PREHEAT);
    `CHK({rd[2:0], prs, ptd, hg}, 6'h0d)
    wait_mode(bmsq_pkg::BMSQ_IGNITION);
    `CHK({rd[2:0], prs, ptd, hg}, 6'h11)
    {oc, rel, trip, wear, busuv} <= 5'h1f;
    repeat (700) @(posedge sys_clk_in);
    `CHK(raise_n > 0, 1'b1)
    stat;
    `CHK(rd[2:0], bmsq_pkg::BMSQ_IGNITION)
    {oc, rel, trip, wear, busuv} <= 5'h00;
    wait_mode(bmsq_pkg::BMSQ_RUN);
    `CHK({rd[16], rd[2:0], wce, bue, hg}, 7'h76)
    oc <= 1'b1;
    m0 = lo_n + 8;
    wait (lo_n >= m0);
    oc <= 1'b0;
    stat;
    `CHK(rd[14:8] != 7'h00, 1'b1)
    m0 = lo_n + 12;
    wait (lo_n >= m0);
    stat;
    `CHK(rd[14:8], 7'h00)
    k = raise_n;
    m0 = lo_n;
    oc <= 1'b1;
    wait_mode(bmsq_pkg::BMSQ_FAULT);
    `CHK((lo_n - m0) inside {[64:66]}, 1'b1)
    `CHK({rd[2:0], fcd, ptd, pge, raise_n == k}, 7'h7d)
    oc <= 1'b0;
    repeat (300) @(posedge sys_clk_in);
    stat;
    `CHK(rd[2:0], bmsq_pkg::BMSQ_FAULT)
    stp <= 1'b1;
    wait_mode(bmsq_pkg::BMSQ_LOCKOUT);
    `CHK({rd[2:0], ptd}, 4'h1)
    {stp, busuv} <= 2'b01;
    wait_mode(bmsq_pkg::BMSQ_FAULT);
    `CHK({rd[17], sd}, 2'h3)
    {rel, trip} <= 2'b11;
    wait_mode(bmsq_pkg::BMSQ_LOCKOUT);
    end_sim;
  end
endmodule
`default_nettype wire
